// >>> hw/iop_defs.svh
// Offsets, field positions, reset values and timing counts for the
// port and processor-control register block.
// Assumes inclusion by bare name from hw/ design files.
`ifndef IOP_DEFS_SVH
`define IOP_DEFS_SVH

// -----------------------------------------------------------------
// Data-space offsets
// -----------------------------------------------------------------
`define IOP_OFS_PB_PIN 8'h23
`define IOP_OFS_PB_DIR 8'h24
`define IOP_OFS_PB_OUT 8'h25
`define IOP_OFS_PC_PIN 8'h26
`define IOP_OFS_PC_DIR 8'h27
`define IOP_OFS_PC_OUT 8'h28
`define IOP_OFS_CTRL 8'h55
`define IOP_IO_BIAS 8'h20
`define IOP_IO_TOP 8'h3F

// -----------------------------------------------------------------
// Control register fields and reset values
// -----------------------------------------------------------------
`define IOP_BIT_VCU 0
`define IOP_BIT_VSEL 1
`define IOP_BIT_PU_OFF 4
`define IOP_BIT_BSDU 5
`define IOP_BIT_BSD 6
`define IOP_RST_BYTE 8'h00
`define IOP_PC_MASK 8'h7F

// -----------------------------------------------------------------
// Timed sequence windows, in clock cycles
// -----------------------------------------------------------------
`define IOP_UNLOCK_CYC 3'h4
`define IOP_BSD_DELAY_CYC 3'h3
`define IOP_BSD_HOLD_CYC 3'h3

`endif

// >>> hw/iop_pkg.sv
// Types shared by the port register block.
// Assumes iop_defs.svh is on the include path.
package iop_pkg;
  typedef enum logic [2:0] {
    IOP_BSD_IDLE = 3'b001,
    IOP_BSD_WAIT = 3'b010,
    IOP_BSD_ON = 3'b100
  } iop_bsd_state_t;
endpackage

// >>> hw/iop_port.sv
// One general-purpose port: data, direction, pin sampling, toggle.
// Assumes register strobes come from the same clock domain.
`include "iop_defs.svh"

module iop_port #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Register strobes
  input wire logic i_wr_out,
  input wire logic i_wr_dir,
  input wire logic i_wr_pin,
  input wire logic [WIDTH-1:0] i_wdata,
  // Global control
  input wire logic i_global_pullup_disable,
  // Pins
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_pin,
  output logic [WIDTH-1:0] o_pin_oe,
  output logic [WIDTH-1:0] o_pullup_en,
  // Register views
  output logic [WIDTH-1:0] o_out_data,
  output logic [WIDTH-1:0] o_dir,
  output logic [WIDTH-1:0] o_pin_level
);

  logic [WIDTH-1:0] out_data;
  logic [WIDTH-1:0] dir;
  logic [WIDTH-1:0] sync_a;
  logic [WIDTH-1:0] sync_b;
  logic [WIDTH-1:0] next_out_data;
  logic [WIDTH-1:0] next_dir;

  // -----------------------------------------------------------------
  // Register update
  // -----------------------------------------------------------------
  always_comb begin
    next_out_data = out_data;
    next_dir = dir;
    if (i_wr_out) begin
      next_out_data = i_wdata;
    end
    if (i_wr_pin) begin
      next_out_data = out_data ^ i_wdata;
    end
    if (i_wr_dir) begin
      next_dir = i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_data <= '0;
      dir <= '0;
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      out_data <= next_out_data;
      dir <= next_dir;
      sync_a <= i_pin;
      sync_b <= sync_a;
    end
  end

  // -----------------------------------------------------------------
  // Pin drive
  // -----------------------------------------------------------------
  assign o_pin = out_data;
  assign o_pin_oe = dir;
  // Pull-up only on inputs with data one, unless globally killed
  assign o_pullup_en = ~dir & out_data &
    {WIDTH{~i_global_pullup_disable}};
  assign o_out_data = out_data;
  assign o_dir = dir;
  assign o_pin_level = sync_b;

endmodule // iop_port

// >>> hw/iop_regs.sv
// Port B, port C and processor control register block.
// Assumes a core-side access port: one-cycle read/write strobes with a
// data-space or I/O-space address, on the system clock.
`include "iop_defs.svh"

// Contract
// - Sleep-disable becomes active three cycles after set, clears three later.
// - Global pull-up disable switches off every port pull-up.
// - Vector select zero puts vectors at zero, one at boot start.
// - Interrupts blocked from unlock until after next instruction, or four cycles.
// - Automatic interrupt blocking leaves the global interrupt flag untouched.
// - Vector unlock clears after four cycles or on vector select write.
// - Boot vectors plus application lock suppress interrupts in application.
// - Application vectors plus boot lock suppress interrupts in boot section.
// - Registers answer at data offset, and I/O offset minus 0x20.
// - Data, direction and sampled pin levels all reset to zero.
// - Writing one to a pin-level bit toggles that data bit.
// - Each direction bit sets its pin's direction, one is output.
// - Port C implements bits 0 to 6 only.
module iop_regs #(
  parameter int PB_WIDTH = 8,
  parameter int PC_WIDTH = 7,
  parameter int PC_ADDR_W = 14
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Core register access
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_io_space,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Core status
  input wire logic i_instr_done,
  input wire logic i_sleep_exec,
  input wire logic [PC_ADDR_W-1:0] i_pc,
  // Fuses and lock bits
  input wire logic [PC_ADDR_W-1:0] i_boot_start,
  input wire logic i_app_section_boot_lock,
  input wire logic i_boot_section_lock,
  // Processor control outputs
  output logic o_vector_table_select,
  output logic [PC_ADDR_W-1:0] o_vector_base,
  output logic o_irq_block,
  output logic o_brownout_sleep_disable,
  output logic o_brownout_detector_off,
  // Port B pins
  input wire logic [PB_WIDTH-1:0] i_pb_pin,
  output logic [PB_WIDTH-1:0] o_pb_pin,
  output logic [PB_WIDTH-1:0] o_pb_pin_oe,
  output logic [PB_WIDTH-1:0] o_pb_pullup_en,
  // Port C pins
  input wire logic [PC_WIDTH-1:0] i_pc_pin,
  output logic [PC_WIDTH-1:0] o_pc_pin,
  output logic [PC_WIDTH-1:0] o_pc_pin_oe,
  output logic [PC_WIDTH-1:0] o_pc_pullup_en
);

  // -----------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------
  logic [7:0] ds_addr;
  logic addr_ok;
  logic sel_pb_pin, sel_pb_dir, sel_pb_out;
  logic sel_pc_pin, sel_pc_dir, sel_pc_out, sel_ctrl;

  // I/O space maps back into data space by adding the bias
  always_comb begin
    ds_addr = i_addr;
    addr_ok = 1'b1;
    if (i_io_space) begin
      addr_ok = (i_addr <= `IOP_IO_TOP);
      ds_addr = i_addr + `IOP_IO_BIAS;
    end
  end

  assign sel_pb_pin = addr_ok && ds_addr == `IOP_OFS_PB_PIN;
  assign sel_pb_dir = addr_ok && ds_addr == `IOP_OFS_PB_DIR;
  assign sel_pb_out = addr_ok && ds_addr == `IOP_OFS_PB_OUT;
  assign sel_pc_pin = addr_ok && ds_addr == `IOP_OFS_PC_PIN;
  assign sel_pc_dir = addr_ok && ds_addr == `IOP_OFS_PC_DIR;
  assign sel_pc_out = addr_ok && ds_addr == `IOP_OFS_PC_OUT;
  assign sel_ctrl = addr_ok && ds_addr == `IOP_OFS_CTRL;

  // -----------------------------------------------------------------
  // Ports
  // -----------------------------------------------------------------
  logic pu_off;
  logic [PB_WIDTH-1:0] pb_out, pb_dir, pb_lvl;
  logic [PC_WIDTH-1:0] pc_out, pc_dir, pc_lvl;

  iop_port #(.WIDTH(PB_WIDTH)) u_port_b (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_wr_out(i_wr && sel_pb_out),
    .i_wr_dir(i_wr && sel_pb_dir),
    .i_wr_pin(i_wr && sel_pb_pin),
    .i_wdata(i_wdata[PB_WIDTH-1:0]),
    .i_global_pullup_disable(pu_off),
    .i_pin(i_pb_pin),
    .o_pin(o_pb_pin),
    .o_pin_oe(o_pb_pin_oe),
    .o_pullup_en(o_pb_pullup_en),
    .o_out_data(pb_out),
    .o_dir(pb_dir),
    .o_pin_level(pb_lvl)
  );

  // Bit 7 of port C has no storage at all
  iop_port #(.WIDTH(PC_WIDTH)) u_port_c (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_wr_out(i_wr && sel_pc_out),
    .i_wr_dir(i_wr && sel_pc_dir),
    .i_wr_pin(i_wr && sel_pc_pin),
    .i_wdata(i_wdata[PC_WIDTH-1:0]),
    .i_global_pullup_disable(pu_off),
    .i_pin(i_pc_pin),
    .o_pin(o_pc_pin),
    .o_pin_oe(o_pc_pin_oe),
    .o_pullup_en(o_pc_pullup_en),
    .o_out_data(pc_out),
    .o_dir(pc_dir),
    .o_pin_level(pc_lvl)
  );

  // -----------------------------------------------------------------
  // Processor control: vector select and its unlock window
  // -----------------------------------------------------------------
  logic ctrl_wr;
  logic vsel, next_vsel;
  logic vcu, next_vcu;
  logic [2:0] vcu_cnt, next_vcu_cnt;
  logic blk_tail, next_blk_tail;
  logic next_pu_off;

  assign ctrl_wr = i_wr && sel_ctrl;

  always_comb begin
    next_vsel = vsel;
    next_vcu = vcu;
    next_vcu_cnt = vcu_cnt;
    next_blk_tail = blk_tail;
    next_pu_off = pu_off;
    if (blk_tail && i_instr_done) begin
      next_blk_tail = 1'b0;
    end
    if (vcu) begin
      next_vcu_cnt = vcu_cnt - 3'h1;
      if (vcu_cnt == 3'h1) begin
        next_vcu = 1'b0;
      end
    end
    if (ctrl_wr) begin
      next_pu_off = i_wdata[`IOP_BIT_PU_OFF];
      if (i_wdata[`IOP_BIT_VCU]) begin
        next_vcu = 1'b1;
        next_vcu_cnt = `IOP_UNLOCK_CYC;
      end else if (vcu) begin
        // Select only changes inside the window
        next_vsel = i_wdata[`IOP_BIT_VSEL];
        next_vcu = 1'b0;
        next_vcu_cnt = 3'h0;
        next_blk_tail = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      vsel <= 1'b0;
      vcu <= 1'b0;
      vcu_cnt <= 3'h0;
      blk_tail <= 1'b0;
      pu_off <= 1'b0;
    end else begin
      vsel <= next_vsel;
      vcu <= next_vcu;
      vcu_cnt <= next_vcu_cnt;
      blk_tail <= next_blk_tail;
      pu_off <= next_pu_off;
    end
  end

  // Blocking is a separate gate; the core's own enable flag is not touched
  logic in_boot;
  assign in_boot = (i_pc >= i_boot_start);
  always_comb begin
    o_irq_block = vcu || blk_tail ||
      (ctrl_wr && i_wdata[`IOP_BIT_VCU]);
    if (vsel && i_app_section_boot_lock && !in_boot) begin
      o_irq_block = 1'b1;
    end
    if (!vsel && i_boot_section_lock && in_boot) begin
      o_irq_block = 1'b1;
    end
  end

  assign o_vector_table_select = vsel;
  assign o_vector_base = vsel ? i_boot_start : '0;

  // -----------------------------------------------------------------
  // Processor control: brown-out sleep disable sequence
  // -----------------------------------------------------------------
  iop_pkg::iop_bsd_state_t bsd_st, next_bsd_st;
  logic bsdu, next_bsdu;
  logic [2:0] bsdu_cnt, next_bsdu_cnt;
  logic [2:0] bsd_cnt, next_bsd_cnt;
  logic bsd_set;

  // Set request only counts while the unlock window is open
  assign bsd_set = ctrl_wr && bsdu && i_wdata[`IOP_BIT_BSD] &&
    !i_wdata[`IOP_BIT_BSDU];

  always_comb begin
    next_bsdu = bsdu;
    next_bsdu_cnt = bsdu_cnt;
    next_bsd_st = bsd_st;
    next_bsd_cnt = bsd_cnt;
    if (bsdu) begin
      next_bsdu_cnt = bsdu_cnt - 3'h1;
      if (bsdu_cnt == 3'h1) begin
        next_bsdu = 1'b0;
      end
    end
    if (ctrl_wr) begin
      if (i_wdata[`IOP_BIT_BSD] && i_wdata[`IOP_BIT_BSDU]) begin
        next_bsdu = 1'b1;
        next_bsdu_cnt = `IOP_UNLOCK_CYC;
      end else begin
        next_bsdu = 1'b0;
        next_bsdu_cnt = 3'h0;
      end
    end
    unique case (bsd_st)
      iop_pkg::IOP_BSD_IDLE: begin
        if (bsd_set) begin
          next_bsd_st = iop_pkg::IOP_BSD_WAIT;
          next_bsd_cnt = `IOP_BSD_DELAY_CYC;
        end
      end
      iop_pkg::IOP_BSD_WAIT: begin
        next_bsd_cnt = bsd_cnt - 3'h1;
        if (bsd_cnt == 3'h1) begin
          next_bsd_st = iop_pkg::IOP_BSD_ON;
          next_bsd_cnt = `IOP_BSD_HOLD_CYC;
        end
      end
      iop_pkg::IOP_BSD_ON: begin
        next_bsd_cnt = bsd_cnt - 3'h1;
        if (bsd_cnt == 3'h1) begin
          next_bsd_st = iop_pkg::IOP_BSD_IDLE;
          next_bsd_cnt = 3'h0;
        end
      end
      default: begin
        next_bsd_st = iop_pkg::IOP_BSD_IDLE;
        next_bsd_cnt = 3'h0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bsd_st <= iop_pkg::IOP_BSD_IDLE;
      bsd_cnt <= 3'h0;
      bsdu <= 1'b0;
      bsdu_cnt <= 3'h0;
    end else begin
      bsd_st <= next_bsd_st;
      bsd_cnt <= next_bsd_cnt;
      bsdu <= next_bsdu;
      bsdu_cnt <= next_bsdu_cnt;
    end
  end

  assign o_brownout_sleep_disable = (bsd_st == iop_pkg::IOP_BSD_ON);
  // Detector only goes off for a sleep taken while the bit is active
  assign o_brownout_detector_off = o_brownout_sleep_disable &&
    i_sleep_exec;

  // -----------------------------------------------------------------
  // Read mux
  // -----------------------------------------------------------------
  logic [7:0] next_rdata;
  logic [7:0] ctrl_view;

  always_comb begin
    ctrl_view = `IOP_RST_BYTE;
    ctrl_view[`IOP_BIT_BSD] = o_brownout_sleep_disable;
    ctrl_view[`IOP_BIT_BSDU] = bsdu;
    ctrl_view[`IOP_BIT_PU_OFF] = pu_off;
    ctrl_view[`IOP_BIT_VSEL] = vsel;
    ctrl_view[`IOP_BIT_VCU] = vcu;
    next_rdata = `IOP_RST_BYTE;
    if (i_rd) begin
      if (sel_pb_pin) next_rdata = pb_lvl;
      if (sel_pb_dir) next_rdata = pb_dir;
      if (sel_pb_out) next_rdata = pb_out;
      if (sel_pc_pin) next_rdata = {1'b0, pc_lvl} & `IOP_PC_MASK;
      if (sel_pc_dir) next_rdata = {1'b0, pc_dir} & `IOP_PC_MASK;
      if (sel_pc_out) next_rdata = {1'b0, pc_out} & `IOP_PC_MASK;
      if (sel_ctrl) next_rdata = ctrl_view;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= `IOP_RST_BYTE;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule // iop_regs

// >>> verification/iop_pin_env.sv
// Model of the circuitry on one port's pins.
// Assumes the bench sets the external drive; one clock, no reset.
module iop_pin_env #(
  parameter int W = 8
) (
  // Clock
  input wire logic i_clk_sys,
  // Port side
  input wire logic [W-1:0] i_out,
  input wire logic [W-1:0] i_oe,
  input wire logic [W-1:0] i_pullup_en,
  // External drive from the bench
  input wire logic [W-1:0] i_ext_en,
  input wire logic [W-1:0] i_ext_val,
  // Pin level
  output logic [W-1:0] o_level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [W-1:0] drift = '0;
  // Floating pins wander so a stale level is never trusted
  always @(posedge i_clk_sys) drift <= ~drift;
  always_comb begin
    for (int b = 0; b < W; b++) begin
      if (i_oe[b]) o_level[b] = i_out[b];
      else if (i_ext_en[b]) o_level[b] = i_ext_val[b];
      else if (i_pullup_en[b]) o_level[b] = 1'b1;
      else o_level[b] = drift[b];
    end
  end
endmodule // iop_pin_env

// >>> verification/iop_regs_chk.sv
// Checker for the port and control register block.
// Assumes it is bound onto iop_regs and sees its ports only.
module iop_regs_chk #(
  parameter int PB_WIDTH = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Core access
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_io_space,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  // Control and locks
  input wire logic i_app_section_boot_lock,
  input wire logic i_boot_section_lock,
  input wire logic o_vector_table_select,
  input wire logic o_irq_block,
  input wire logic o_brownout_sleep_disable,
  // Port B
  input wire logic [PB_WIDTH-1:0] o_pb_pin,
  input wire logic [PB_WIDTH-1:0] o_pb_pin_oe,
  input wire logic [PB_WIDTH-1:0] o_pb_pullup_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] eff;
  logic ok_io;
  logic hit;
  logic ctl;
  logic lk;
  assign eff = i_io_space ? i_addr + 8'h20 : i_addr;
  assign ok_io = !i_io_space || i_addr <= 8'h3F;
  assign hit = ok_io && (eff == 8'h55 || (eff >= 8'h23 && eff <= 8'h28));
  assign ctl = i_wr && ok_io && eff == 8'h55;
  // Lock bits may hold the block on their own
  assign lk = i_app_section_boot_lock || i_boot_section_lock;
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_unlock;
    ctl && i_wdata[0];
  endsequence
  sequence s_arm;
    ctl && i_wdata[6:5] == 2'b11;
  endsequence
  sequence s_set;
    ctl && i_wdata[6:5] == 2'b10;
  endsequence
  // --------
  // Assertions
  // --------
  a_block_on_unlock: assert property (s_unlock |-> o_irq_block[*2])
    else $error("no block after unlock");
  a_block_expire: assert property (
    s_unlock ##1 (!ctl)[*5] |-> !o_irq_block || lk)
    else $error("block outlived window");
  a_vsel_load: assert property (
    s_unlock ##1 !ctl ##1 (ctl && !i_wdata[0])
      |=> o_vector_table_select == $past(i_wdata[1]))
    else $error("select not loaded");
  a_vsel_guard: assert property (!ctl |=> $stable(o_vector_table_select))
    else $error("select moved unbidden");
  a_bsd_timing: assert property (
    s_arm ##1 !ctl ##1 s_set |-> ##1 (!o_brownout_sleep_disable)[*3]
      ##1 o_brownout_sleep_disable[*3] ##1 !o_brownout_sleep_disable)
    else $error("sleep disable timing");
  a_pullup_gate: assert property (
    (o_pb_pullup_en & (o_pb_pin_oe | ~o_pb_pin)) == '0)
    else $error("pull-up on wrong pin");
  a_pullup_off: assert property (ctl && i_wdata[4] |=> o_pb_pullup_en == '0)
    else $error("pull-up not disabled");
  a_dir_write: assert property (
    i_wr && ok_io && eff == 8'h24 |=> o_pb_pin_oe == $past(i_wdata))
    else $error("direction not written");
  a_rdata_idle: assert property (!i_rd || !hit |=> o_rdata == 8'h00)
    else $error("read data not zero");
endmodule // iop_regs_chk

bind iop_regs iop_regs_chk #(.PB_WIDTH(PB_WIDTH)) u_chk (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_wr(i_wr), .i_rd(i_rd),
  .i_io_space(i_io_space), .i_addr(i_addr), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .i_app_section_boot_lock(i_app_section_boot_lock),
  .i_boot_section_lock(i_boot_section_lock), .o_irq_block(o_irq_block),
  .o_vector_table_select(o_vector_table_select), .o_pb_pin(o_pb_pin),
  .o_brownout_sleep_disable(o_brownout_sleep_disable),
  .o_pb_pin_oe(o_pb_pin_oe), .o_pb_pullup_en(o_pb_pullup_en));

// >>> verification/iop_regs_tb.sv
// Bench for the port and control register block.
// Assumes iop_regs with a pin model on each port.
module iop_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst, i_wr, i_rd, i_io_space, i_instr_done, i_sleep_exec;
  logic i_app_section_boot_lock, i_boot_section_lock, vsel, blk, bsd, boff;
  logic [7:0] i_addr, i_wdata, o_rdata, pb_lvl, pb_oe, pb_out, pb_pu;
  logic [7:0] pb_ext_en, pb_ext_val;
  logic [6:0] pc_lvl, pc_oe, pc_out, pc_pu;
  logic [13:0] i_pc, i_boot_start, vbase;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  iop_regs uut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_wr(i_wr),
    .i_rd(i_rd), .i_io_space(i_io_space), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .i_instr_done(i_instr_done), .i_pc(i_pc),
    .i_sleep_exec(i_sleep_exec), .i_boot_start(i_boot_start),
    .i_app_section_boot_lock(i_app_section_boot_lock),
    .i_boot_section_lock(i_boot_section_lock), .o_irq_block(blk),
    .o_vector_table_select(vsel), .o_vector_base(vbase),
    .o_brownout_sleep_disable(bsd), .o_brownout_detector_off(boff),
    .i_pb_pin(pb_lvl), .o_pb_pin(pb_out), .o_pb_pin_oe(pb_oe),
    .o_pb_pullup_en(pb_pu), .i_pc_pin(pc_lvl), .o_pc_pin(pc_out),
    .o_pc_pin_oe(pc_oe), .o_pc_pullup_en(pc_pu));
  iop_pin_env #(.W(8)) u_pb (.i_clk_sys(i_clk_sys), .i_out(pb_out),
    .i_oe(pb_oe), .i_pullup_en(pb_pu), .i_ext_en(pb_ext_en),
    .i_ext_val(pb_ext_val), .o_level(pb_lvl));
  iop_pin_env #(.W(7)) u_pc (.i_clk_sys(i_clk_sys), .i_out(pc_out),
    .i_oe(pc_oe), .i_pullup_en(pc_pu), .i_ext_en(7'h00),
    .i_ext_val(7'h00), .o_level(pc_lvl));
  // --------
  // Tasks
  // --------
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Drives start on an edge; checks land 1 ns after it
  task automatic wr(logic io, logic [7:0] a, logic [7:0] d);
    @(posedge i_clk_sys);
    i_io_space <= io;
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(logic io, logic [7:0] a, logic [7:0] e);
    @(posedge i_clk_sys);
    i_io_space <= io;
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  task automatic set_pc(logic [13:0] p);
    @(posedge i_clk_sys);
    i_pc <= p;
    #1;
  endtask
  task automatic move(logic v);
    wr(1'b1, 8'h35, 8'h01);
    chk(blk, 16'h0001);
    wr(1'b1, 8'h35, {6'h00, v, 1'b0});
    chk(vsel, 16'(v));
    chk(blk, 16'h0001);
    @(posedge i_clk_sys);
    i_instr_done <= 1'b1;
    @(posedge i_clk_sys);
    i_instr_done <= 1'b0;
    #1 chk(blk, 16'h0000);
  endtask
  task automatic finish_test();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // --------
  // Scenarios
  // --------
  task automatic t_map();
    rchk(1'b0, 8'h24, 8'h00);
    rchk(1'b0, 8'h28, 8'h00);
    rchk(1'b0, 8'h55, 8'h00);
    wr(1'b1, 8'h04, 8'hA5);
    rchk(1'b0, 8'h24, 8'hA5);
    chk(pb_oe, 16'h00A5);
    wr(1'b0, 8'h25, 8'h3C);
    rchk(1'b1, 8'h05, 8'h3C);
    wr(1'b0, 8'h28, 8'hFF);
    wr(1'b1, 8'h07, 8'hFF);
    rchk(1'b1, 8'h08, 8'h7F);
    rchk(1'b0, 8'h27, 8'h7F);
    wr(1'b0, 8'h35, 8'hFF);
    rchk(1'b0, 8'h55, 8'h00);
    rchk(1'b1, 8'h30, 8'h00);
    rchk(1'b1, 8'h40, 8'h00);
    wr(1'b0, 8'h23, 8'h0F);
    rchk(1'b0, 8'h25, 8'h33);
    wr(1'b1, 8'h06, 8'h41);
    rchk(1'b0, 8'h28, 8'h3E);
  endtask
  task automatic t_pins();
    @(posedge i_clk_sys);
    pb_ext_en <= 8'h5A;
    pb_ext_val <= 8'h48;
    repeat (3) @(posedge i_clk_sys);
    rchk(1'b1, 8'h03, 8'h69);
    rchk(1'b1, 8'h06, 8'h3E);
    @(posedge i_clk_sys);
    pb_ext_en <= 8'h00;
    wr(1'b0, 8'h24, 8'h00);
    wr(1'b1, 8'h07, 8'h00);
    chk(pb_pu, 16'h0033);
    chk(pc_pu, 16'h003E);
    wr(1'b1, 8'h35, 8'h10);
    chk(pb_pu, 16'h0000);
    chk(pc_pu, 16'h0000);
    rchk(1'b0, 8'h55, 8'h10);
    wr(1'b1, 8'h35, 8'h00);
    chk(pb_pu, 16'h0033);
  endtask
  task automatic t_vector();
    chk(vbase, 16'h0000);
    move(1'b1);
    chk(vbase, 16'h3C00);
    rchk(1'b0, 8'h55, 8'h02);
    wr(1'b1, 8'h35, 8'h00);
    chk(vsel, 16'h0001);
    wr(1'b1, 8'h35, 8'h01);
    rchk(1'b1, 8'h35, 8'h03);
    repeat (4) @(posedge i_clk_sys);
    #1 chk(blk, 16'h0000);
    rchk(1'b0, 8'h55, 8'h02);
    move(1'b0);
    chk(vbase, 16'h0000);
  endtask
  task automatic t_brownout();
    @(posedge i_clk_sys);
    i_sleep_exec <= 1'b1;
    wr(1'b1, 8'h35, 8'h40);
    for (int k = 0; k < 6; k++) begin
      chk(bsd, 16'h0000);
      @(posedge i_clk_sys);
      #1;
    end
    wr(1'b1, 8'h35, 8'h60);
    wr(1'b1, 8'h35, 8'h40);
    for (int k = 0; k < 7; k++) begin
      chk(bsd, 16'(k >= 3 && k <= 5));
      chk(boff, 16'(k >= 3 && k <= 5));
      @(posedge i_clk_sys);
      #1;
    end
  endtask
  task automatic t_locks();
    @(posedge i_clk_sys);
    i_boot_section_lock <= 1'b1;
    set_pc(14'h3C10);
    chk(blk, 16'h0001);
    set_pc(14'h0010);
    chk(blk, 16'h0000);
    @(posedge i_clk_sys);
    i_boot_section_lock <= 1'b0;
    move(1'b1);
    @(posedge i_clk_sys);
    i_app_section_boot_lock <= 1'b1;
    set_pc(14'h0010);
    chk(blk, 16'h0001);
    set_pc(14'h3C10);
    chk(blk, 16'h0000);
  endtask
  initial begin
    i_sys_rst = 1'b1;
    {i_wr, i_rd, i_io_space, i_instr_done, i_sleep_exec} = 5'h00;
    {i_app_section_boot_lock, i_boot_section_lock} = 2'h0;
    {i_addr, i_wdata, pb_ext_en, pb_ext_val} = 32'h00000000;
    i_pc = 14'h0000;
    i_boot_start = 14'h3C00;
    repeat (2) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    t_map();
    t_pins();
    t_vector();
    t_brownout();
    t_locks();
    finish_test();
  end
  // Whole run needs well under a thousand cycles
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      finish_test();
    end
  end
endmodule // iop_regs_tb
